// *** verilog/sfl_cfg.svh ***
// constants for the serial flash write-command block
`ifndef SFL_CFG_SVH
`define SFL_CFG_SVH
`define SFL_OPC_WRITE_ENABLE 8'h06
`define SFL_OPC_PAGE_REWRITE 8'h0a
`define SFL_OPC_PAGE_PROGRAM 8'h02
`define SFL_OPC_LOCK_WRITE 8'he5
`define SFL_ADDR_W 19
`define SFL_COL_W 8
`define SFL_PAGE_W 11
`define SFL_PAGE_BYTES 256
`define SFL_SECT_LSB 16
`define SFL_SECTORS 8
`define SFL_IDX_OPC 3'h0
`define SFL_IDX_ADDR_HI 3'h1
`define SFL_IDX_ADDR_MID 3'h2
`define SFL_IDX_ADDR_LO 3'h3
`define SFL_CNT_OPC_ONLY 3'h1
`define SFL_CNT_FIRST_DATA 3'h5
`define SFL_CNT_SAT 3'h6
`define SFL_BIT_LAST 3'h7
`define SFL_COL_LAST 8'hff
`define SFL_DRAIN_LAST 8'h01
`define SFL_LOCK_WR_BIT 0
`define SFL_LOCK_DN_BIT 1
`define SFL_LOCK_RSVD 6'h00
`define SFL_CLK_PERIOD_NS 10
`define SFL_PAGE_REWRITE_TIME_NS 200000
`define SFL_PAGE_PROGRAM_TIME_NS 100000
`endif

// *** verilog/sfl_pkg.sv ***
// types shared by the serial flash write-command block
`default_nettype none
`include "sfl_cfg.svh"
package sfl_pkg;
	typedef enum logic [2:0] {
		ST_IDLE  = 3'b001,
		ST_FRAME = 3'b010,
		ST_EXEC  = 3'b100
	} sfl_state_t;
	typedef enum logic [5:0] {
		EX_IDLE  = 6'h01,
		EX_READ  = 6'h02,
		EX_DRAIN = 6'h04,
		EX_ERASE = 6'h08,
		EX_WRITE = 6'h10,
		EX_WAIT  = 6'h20
	} sfl_exe_state_t;
	typedef enum logic {
		MODE_REWRITE = 1'b0,
		MODE_PROGRAM = 1'b1
	} sfl_mode_t;
	typedef struct packed {
		logic                   erase;
		logic                   write;
		sfl_mode_t              mode;
		logic [`SFL_ADDR_W-1:0] addr;
		logic [7:0]             data;
	} sfl_arr_req_t;
endpackage
`default_nettype wire

// *** verilog/sfl_page_exec.sv ***
// self-timed page cycle: read-merge, optional erase, write-back, hold
`default_nettype none
`include "sfl_cfg.svh"
module sfl_page_exec #(
	parameter int REWRITE_CYC = 20000,
	parameter int PROGRAM_CYC = 10000
) (
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic                    start_i,
	input  wire sfl_pkg::sfl_mode_t      mode_i,
	input  wire logic [`SFL_PAGE_W-1:0]  page_i,
	input  wire logic [7:0]              buf_byte_i,
	output logic [`SFL_COL_W-1:0]        col_o,
	output logic                         merge_o,
	output logic [`SFL_COL_W-1:0]        merge_col_o,
	output logic                         latch_clr_o,
	output logic                         busy_o,
	output sfl_pkg::sfl_arr_req_t        arr_req_o
);
	localparam int MAXC = (REWRITE_CYC > PROGRAM_CYC) ? REWRITE_CYC : PROGRAM_CYC;
	localparam int TW = $clog2(MAXC + 1);

	sfl_pkg::sfl_exe_state_t state, next_state;
	sfl_pkg::sfl_mode_t      mode, next_mode;
	sfl_pkg::sfl_arr_req_t   arr, next_arr;
	logic [`SFL_COL_W-1:0]   cnt, next_cnt, pcol1, next_pcol1, pcol2, next_pcol2;
	logic [`SFL_PAGE_W-1:0]  page, next_page;
	logic [TW-1:0]           timer, next_timer;
	logic [1:0]              pend, next_pend;

	// sequence one page cycle
	always_comb begin
		next_state = state;
		next_cnt = cnt;
		next_timer = (timer != '0) ? timer - TW'(1) : timer;
		next_mode = mode;
		next_page = page;
		next_pend = {pend[0], 1'b0};
		next_pcol1 = pcol1;
		next_pcol2 = pcol1;
		next_arr = '0;
		next_arr.mode = mode;
		case (state)
			sfl_pkg::EX_IDLE: begin
				if (start_i) begin
					next_state = sfl_pkg::EX_READ;
					next_cnt = '0;
					next_mode = mode_i;
					next_page = page_i;
					next_timer = (mode_i == sfl_pkg::MODE_PROGRAM) ?
						TW'(PROGRAM_CYC - 1) : TW'(REWRITE_CYC - 1);
				end
			end
			sfl_pkg::EX_READ: begin
				next_arr.addr = {page, cnt};
				next_pend[0] = 1'b1;
				next_pcol1 = cnt;
				next_cnt = cnt + 8'h01;
				if (cnt == `SFL_COL_LAST) begin
					next_state = sfl_pkg::EX_DRAIN;
				end
			end
			sfl_pkg::EX_DRAIN: begin
				next_cnt = cnt + 8'h01;
				if (cnt == `SFL_DRAIN_LAST) begin
					next_cnt = '0;
					next_state = (mode == sfl_pkg::MODE_REWRITE) ?
						sfl_pkg::EX_ERASE : sfl_pkg::EX_WRITE;
				end
			end
			sfl_pkg::EX_ERASE: begin
				next_arr.erase = 1'b1; // whole page erased first
				next_arr.addr = {page, 8'h00};
				next_state = sfl_pkg::EX_WRITE;
			end
			sfl_pkg::EX_WRITE: begin
				next_arr.write = 1'b1; // every byte written back
				next_arr.addr = {page, cnt};
				next_arr.data = buf_byte_i;
				next_cnt = cnt + 8'h01;
				if (cnt == `SFL_COL_LAST) begin
					next_state = sfl_pkg::EX_WAIT;
				end
			end
			sfl_pkg::EX_WAIT: begin
				if (timer == '0) begin
					next_state = sfl_pkg::EX_IDLE;
				end
			end
			default: next_state = sfl_pkg::EX_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= sfl_pkg::EX_IDLE;
			mode <= sfl_pkg::MODE_REWRITE;
			arr <= '0;
			cnt <= '0;
			pcol1 <= '0;
			pcol2 <= '0;
			page <= '0;
			timer <= '0;
			pend <= '0;
		end else begin
			state <= next_state;
			mode <= next_mode;
			arr <= next_arr;
			cnt <= next_cnt;
			pcol1 <= next_pcol1;
			pcol2 <= next_pcol2;
			page <= next_page;
			timer <= next_timer;
			pend <= next_pend;
		end
	end

	// outputs
	assign col_o = cnt;
	assign merge_o = pend[1];
	assign merge_col_o = pcol2;
	assign latch_clr_o = (state == sfl_pkg::EX_WRITE) && (cnt == '0);
	assign busy_o = (state != sfl_pkg::EX_IDLE);
	assign arr_req_o = arr;

	// busy length helper
	logic [31:0] run_cnt;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_cnt <= '0;
		end else begin
			run_cnt <= busy_o ? run_cnt + 32'h1 : '0;
		end
	end

	erase_mode_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		arr_req_o.erase |-> arr_req_o.mode == sfl_pkg::MODE_REWRITE ##1 arr_req_o.write)
		else $error("page erase outside a rewrite");
	busy_len_a: assert property (@(posedge clk_i) disable iff (!rst_n_i)
		$fell(busy_o) |-> run_cnt == ((mode == sfl_pkg::MODE_PROGRAM) ?
			PROGRAM_CYC : REWRITE_CYC))
		else $error("page cycle length wrong");
	erase_c: cover property (@(posedge clk_i) disable iff (!rst_n_i) arr_req_o.erase);
endmodule
`default_nettype wire

// *** verilog/sfl_flash_wr_cmds.sv ***
// serial flash write-type commands: link shifter, decode, page buffer, locks
`default_nettype none
`include "sfl_cfg.svh"
// How it works
// - page rewrite, page program and lock write need the write enable latch set.
// - page rewrite erases the page and rewrites untouched bytes unchanged.
// - data past the page end wraps to column zero of the page.
// - more than 256 bytes: only the last 256 are kept.
// - short sequences change only the addressed bytes.
// - deselect off a byte boundary discards the command.
// - deselect starts the timed page rewrite cycle.
// - deselect starts the timed page program cycle.
// - busy flag is 1 during the cycle, 0 after, pollable.
// - write enable latch clears before the cycle ends.
// - hardware protected pages are never written.
// - write-type commands are refused while any cycle runs.
// - page program only clears bits from 1 to 0.
// - the top five address bits are ignored.
// - lock write is opcode, address, one data byte, then deselect.
// - lock bits update at once and the latch clears quickly.
// - a write-locked sector takes no write or program.
// - lock-down freezes both sector bits until reset.
module sfl_flash_wr_cmds #(
	parameter int PAGE_REWRITE_TIME_NS = `SFL_PAGE_REWRITE_TIME_NS,
	parameter int PAGE_PROGRAM_TIME_NS = `SFL_PAGE_PROGRAM_TIME_NS,
	parameter int SECTORS              = `SFL_SECTORS
) (
	input  wire logic                   clk_i,
	input  wire logic                   rst_n_i,
	input  wire logic                   sclk_i,
	input  wire logic                   cs_n_i,
	input  wire logic                   mosi_i,
	input  wire logic                   ext_busy_i,
	input  wire logic                   page_hw_prot_i,
	input  wire logic [7:0]             arr_rd_data_i,
	output logic [`SFL_PAGE_W-1:0]      target_page_o,
	output logic                        busy_flag_o,
	output logic                        write_enable_latch_o,
	output logic [SECTORS-1:0][7:0]     sector_lock_bits_o,
	output sfl_pkg::sfl_arr_req_t       arr_req_o
);
	localparam int REWRITE_CYC =
		(PAGE_REWRITE_TIME_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS;
	localparam int PROGRAM_CYC =
		(PAGE_PROGRAM_TIME_NS + `SFL_CLK_PERIOD_NS - 1) / `SFL_CLK_PERIOD_NS;

	// ---- link domain (serial clock) ----
	logic       lk_fresh;
	logic [2:0] lk_cnt, next_lk_cnt;
	logic [6:0] lk_shift, next_lk_shift;
	logic [7:0] lk_byte, next_lk_byte;
	logic       lk_tgl, next_lk_tgl;
	logic       lk_mid, next_lk_mid;

	// frame-start marker, held set while deselected or in reset
	logic lk_set;
	assign lk_set = cs_n_i | ~rst_n_i; // marker is known before the first frame
	always_ff @(posedge sclk_i or posedge lk_set) begin
		if (lk_set) begin
			lk_fresh <= 1'b1;
		end else begin
			lk_fresh <= 1'b0;
		end
	end

	// bit shifter; a toggle marks each whole byte
	always_comb begin
		next_lk_cnt = lk_fresh ? 3'h1 : lk_cnt + 3'h1;
		next_lk_shift = lk_fresh ? {6'h00, mosi_i} : {lk_shift[5:0], mosi_i};
		next_lk_byte = lk_byte;
		next_lk_tgl = lk_tgl;
		if (!lk_fresh && lk_cnt == `SFL_BIT_LAST) begin
			next_lk_byte = {lk_shift, mosi_i};
			next_lk_tgl = ~lk_tgl;
		end
		next_lk_mid = (next_lk_cnt != 3'h0); // partial byte pending
	end

	always_ff @(posedge sclk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			lk_cnt <= '0;
			lk_shift <= '0;
			lk_byte <= '0;
			lk_tgl <= 1'b0;
			lk_mid <= 1'b0;
		end else begin
			lk_cnt <= next_lk_cnt;
			lk_shift <= next_lk_shift;
			lk_byte <= next_lk_byte;
			lk_tgl <= next_lk_tgl;
			lk_mid <= next_lk_mid;
		end
	end

	// ---- crossings into the system clock ----
	logic [3:0] cs_sync, next_cs_sync;
	logic [2:0] tg_sync, next_tg_sync;
	logic [1:0] md_sync, next_md_sync;

	// chip select gets one extra stage so bytes land before the frame end
	always_comb begin
		next_cs_sync = {cs_sync[2:0], cs_n_i};
		next_tg_sync = {tg_sync[1:0], lk_tgl};
		next_md_sync = {md_sync[0], lk_mid};
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			cs_sync <= 4'hf;
			tg_sync <= '0;
			md_sync <= '0;
		end else begin
			cs_sync <= next_cs_sync;
			tg_sync <= next_tg_sync;
			md_sync <= next_md_sync;
		end
	end

	logic frame_end;
	logic byte_ev;
	logic mid_q;
	assign frame_end = cs_sync[2] & ~cs_sync[3]; // deselect closes the frame
	assign byte_ev = tg_sync[1] ^ tg_sync[2];
	assign mid_q = md_sync[1];

	// ---- command state ----
	sfl_pkg::sfl_state_t     state, next_state;
	sfl_pkg::sfl_mode_t      mode, next_mode;
	logic [7:0]              opcode, next_opcode;
	logic [`SFL_ADDR_W-1:0]  addr, next_addr;
	logic [2:0]              nbyte, next_nbyte;
	logic [`SFL_COL_W-1:0]   col, next_col;
	logic [`SFL_PAGE_BYTES-1:0] mask, next_mask;
	logic [7:0]              ldata, next_ldata;
	logic                    wr_latch, next_wr_latch;
	logic [SECTORS-1:0]      wlock, next_wlock;
	logic [SECTORS-1:0]      ldown, next_ldown;
	logic [7:0]              pbuf [0:`SFL_PAGE_BYTES-1];
	logic                    buf_we;
	logic [`SFL_COL_W-1:0]   buf_idx;
	logic [7:0]              buf_val;
	logic                    exe_start;
	logic                    lock_done;
	logic                    data_we;
	logic                    busy_all;
	logic                    page_cmd;
	logic [`SFL_ADDR_W-`SFL_SECT_LSB-1:0] sect;

	// executor wires
	logic                    exe_busy;
	logic                    exe_merge;
	logic                    exe_latch_clr;
	logic [`SFL_COL_W-1:0]   exe_col;
	logic [`SFL_COL_W-1:0]   merge_col;

	assign busy_all = exe_busy | ext_busy_i;
	assign page_cmd = (opcode == `SFL_OPC_PAGE_REWRITE) ||
		(opcode == `SFL_OPC_PAGE_PROGRAM);
	assign sect = addr[`SFL_ADDR_W-1:`SFL_SECT_LSB];

	// byte decode, page buffer, end-of-frame decision, frame state
	always_comb begin
		next_state = state;
		next_mode = mode;
		next_opcode = opcode;
		next_addr = addr;
		next_nbyte = nbyte;
		next_col = col;
		next_mask = mask;
		next_ldata = ldata;
		next_wr_latch = wr_latch;
		next_wlock = wlock;
		next_ldown = ldown;
		exe_start = 1'b0;
		lock_done = 1'b0;
		data_we = 1'b0;
		buf_we = 1'b0;
		buf_idx = col;
		buf_val = lk_byte;
		// read pass of a running cycle merges old page contents
		if (exe_merge) begin
			buf_we = 1'b1;
			buf_idx = merge_col;
			if (!mask[merge_col]) begin
				buf_val = arr_rd_data_i; // untouched bytes keep old value
			end else if (mode == sfl_pkg::MODE_PROGRAM) begin
				buf_val = arr_rd_data_i & pbuf[merge_col]; // only 1 to 0
			end else begin
				buf_val = pbuf[merge_col];
			end
		end
		// byte position decides its meaning
		if (byte_ev) begin
			if (nbyte != `SFL_CNT_SAT) begin
				next_nbyte = nbyte + 3'h1;
			end
			case (nbyte)
				`SFL_IDX_OPC: begin
					next_opcode = lk_byte;
					if (!busy_all) begin
						next_mask = '0;
					end
				end
				`SFL_IDX_ADDR_HI: begin
					// upper five bits dropped
					next_addr[`SFL_ADDR_W-1:`SFL_SECT_LSB] =
						lk_byte[`SFL_ADDR_W-`SFL_SECT_LSB-1:0];
				end
				`SFL_IDX_ADDR_MID: begin
					next_addr[`SFL_SECT_LSB-1:`SFL_COL_W] = lk_byte;
				end
				`SFL_IDX_ADDR_LO: begin
					next_addr[`SFL_COL_W-1:0] = lk_byte;
					next_col = lk_byte;
				end
				default: begin
					next_ldata = lk_byte;
					if (page_cmd && !busy_all) begin
						// later bytes overwrite earlier ones
						data_we = 1'b1;
						buf_we = 1'b1;
						next_mask[col] = 1'b1;
						next_col = col + 8'h01; // wraps inside the page
					end
				end
			endcase
		end
		// decision at deselect
		if (frame_end) begin
			next_nbyte = `SFL_IDX_OPC;
			case (opcode)
				`SFL_OPC_WRITE_ENABLE: begin
					if (nbyte == `SFL_CNT_OPC_ONLY && !mid_q && !busy_all) begin
						next_wr_latch = 1'b1;
					end
				end
				`SFL_OPC_PAGE_REWRITE, `SFL_OPC_PAGE_PROGRAM: begin
					// latch, idle, whole bytes, >=1 data, unprotected
					if (wr_latch && !busy_all && !mid_q &&
						nbyte >= `SFL_CNT_FIRST_DATA &&
						!page_hw_prot_i && !wlock[sect]) begin
						exe_start = 1'b1;
						next_mode = (opcode == `SFL_OPC_PAGE_PROGRAM) ?
							sfl_pkg::MODE_PROGRAM : sfl_pkg::MODE_REWRITE;
					end
				end
				`SFL_OPC_LOCK_WRITE: begin
					// exactly one data byte; frozen sectors refuse
					if (wr_latch && !busy_all && !mid_q &&
						nbyte == `SFL_CNT_FIRST_DATA && !ldown[sect]) begin
						lock_done = 1'b1;
						next_wlock[sect] = ldata[`SFL_LOCK_WR_BIT];
						next_ldown[sect] = ldata[`SFL_LOCK_DN_BIT];
						next_wr_latch = 1'b0;
					end
				end
				default: ;
			endcase
		end
		// latch drops inside the running cycle
		if (exe_latch_clr) begin
			next_wr_latch = 1'b0;
		end
		case (state)
			sfl_pkg::ST_IDLE: begin
				if (exe_start) begin
					next_state = sfl_pkg::ST_EXEC;
				end else if (!cs_sync[2]) begin
					next_state = sfl_pkg::ST_FRAME;
				end
			end
			sfl_pkg::ST_FRAME: begin
				if (frame_end) begin
					next_state = exe_start ? sfl_pkg::ST_EXEC : sfl_pkg::ST_IDLE;
				end
			end
			sfl_pkg::ST_EXEC: begin
				if (!exe_busy && !exe_start) begin
					next_state = sfl_pkg::ST_IDLE;
				end
			end
			default: next_state = sfl_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			state <= sfl_pkg::ST_IDLE;
			mode <= sfl_pkg::MODE_REWRITE;
			opcode <= '0;
			addr <= '0;
			nbyte <= `SFL_IDX_OPC;
			col <= '0;
			mask <= '0;
			ldata <= '0;
			wr_latch <= 1'b0;
			wlock <= '0; // both lock bits default to 0
			ldown <= '0;
		end else begin
			state <= next_state;
			mode <= next_mode;
			opcode <= next_opcode;
			addr <= next_addr;
			nbyte <= next_nbyte;
			col <= next_col;
			mask <= next_mask;
			ldata <= next_ldata;
			wr_latch <= next_wr_latch;
			wlock <= next_wlock;
			ldown <= next_ldown;
		end
	end

	// page buffer storage
	always_ff @(posedge clk_i) begin
		if (buf_we) begin
			pbuf[buf_idx] <= buf_val;
		end
	end

	// page cycle executor; page taken once at start
	sfl_page_exec #(
		.REWRITE_CYC (REWRITE_CYC),
		.PROGRAM_CYC (PROGRAM_CYC)
	) u_exec (
		.clk_i       (clk_i),
		.rst_n_i     (rst_n_i),
		.start_i     (exe_start),
		.mode_i      (next_mode),
		.page_i      (addr[`SFL_ADDR_W-1:`SFL_COL_W]),
		.buf_byte_i  (pbuf[exe_col]),
		.col_o       (exe_col),
		.merge_o     (exe_merge),
		.merge_col_o (merge_col),
		.latch_clr_o (exe_latch_clr),
		.busy_o      (exe_busy),
		.arr_req_o   (arr_req_o)
	);

	// status outputs and per-sector lock bytes
	assign target_page_o = addr[`SFL_ADDR_W-1:`SFL_COL_W];
	assign busy_flag_o = exe_busy;
	assign write_enable_latch_o = wr_latch;
	for (genvar s = 0; s < SECTORS; s++) begin : g_lock
		assign sector_lock_bits_o[s] = {`SFL_LOCK_RSVD, ldown[s], wlock[s]};
	end

	// ---- checks ----
	logic [`SFL_PAGE_W-1:0] run_page;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			run_page <= '0;
		end else if (exe_start) begin
			run_page <= addr[`SFL_ADDR_W-1:`SFL_COL_W];
		end
	end

	default clocking dc @(posedge clk_i);
	endclocking
	default disable iff (!rst_n_i);

	exec_state_a: assert property (busy_flag_o |-> state == sfl_pkg::ST_EXEC)
		else $error("busy flag outside the run state");
	latch_gate_a: assert property (exe_start || lock_done |-> wr_latch)
		else $error("write-type command ran without latch");
	busy_rise_a: assert property (exe_start |=> busy_flag_o ##1 busy_flag_o)
		else $error("busy flag not raised by page cycle");
	latch_clear_a: assert property ($fell(busy_flag_o) |-> !wr_latch)
		else $error("latch still set after page cycle");
	page_hold_a: assert property ((arr_req_o.write || arr_req_o.erase) |->
		arr_req_o.addr[`SFL_ADDR_W-1:`SFL_COL_W] == run_page)
		else $error("page cycle touched another page");
	col_wrap_a: assert property (data_we |=> col == $past(col) + 8'h01)
		else $error("column did not advance with wrap");
	mid_drop_a: assert property (frame_end && mid_q && !busy_all |->
		!exe_start ##1 ($stable(wr_latch) && $stable(sector_lock_bits_o)))
		else $error("command off a byte boundary was kept");
	busy_rej_a: assert property (frame_end && busy_all |->
		!exe_start && !lock_done ##1 $stable(sector_lock_bits_o))
		else $error("command accepted during a cycle");
	prot_chk_a: assert property (exe_start |-> !page_hw_prot_i && !wlock[sect])
		else $error("protected page started a cycle");
	lock_down_a: assert property ((((ldown ^ $past(ldown)) |
		(wlock ^ $past(wlock))) & $past(ldown)) == '0)
		else $error("locked-down sector bits changed");
	lock_latch_a: assert property (lock_done |=> !wr_latch && !busy_flag_o)
		else $error("latch not cleared after lock write");

	rewrite_c: cover property (exe_start && next_mode == sfl_pkg::MODE_REWRITE);
	program_c: cover property (exe_start && next_mode == sfl_pkg::MODE_PROGRAM);
	lock_c: cover property (lock_done);
	drop_c: cover property (frame_end && mid_q);
endmodule
`default_nettype wire

// *** bench/sfl_host_model.sv ***
// host link model: frames whole or cut bytes on the serial link
`default_nettype none
module sfl_host_model (
	output var logic cs_n_o,
	output var logic sclk_o,
	output var logic mosi_o
);
	timeunit 1ns;
	timeprecision 100ps;

	// idle link, clock stands still outside frames
	initial begin
		cs_n_o = 1'b1;
		sclk_o = 1'b0;
		mosi_o = 1'b0;
	end

	// bytes msb first, then cut_bits of a stray byte to break framing
	task automatic frame(input logic [7:0] q[$], input int cut_bits);
		int k;
		int n;
		n = q.size() * 8 + cut_bits;
		#80.3 cs_n_o = 1'b0; // spacing before select
		for (k = 0; k < n; k++) begin
			mosi_o = (k < q.size() * 8) ? q[k / 8][7 - k % 8] : 1'b1;
			#6 sclk_o = 1'b1;
			#6 sclk_o = 1'b0;
		end
		mosi_o = ~mosi_o; // released line shows no stale bit
		#25 cs_n_o = 1'b1; // deselect after last bit
	endtask
endmodule
`default_nettype wire

// *** bench/test_serial_flash_page_write_lock_cmds.sv ***
// bench for the serial flash write-command block
`default_nettype none
`include "sfl_cfg.svh"
module test_serial_flash_page_write_lock_cmds;
	timeunit 1ns;
	timeprecision 100ps;
	localparam int RW_CYC = 8000 / `SFL_CLK_PERIOD_NS;
	localparam int PG_CYC = 6000 / `SFL_CLK_PERIOD_NS;
	logic                  clk, rst_n, sclk, cs_n, mosi, ext_busy, hw_prot, busy, wr_latch;
	logic [7:0]            rd_data;
	logic [10:0]           page;
	logic [7:0][7:0]       locks;
	sfl_pkg::sfl_arr_req_t arr;
	logic [7:0]            mem [int];
	int                    error_cnt, samples_checked, erase_cnt, c;

	// clock and time-zero input values
	initial clk = 1'b0;
	always #5 clk = ~clk;
	initial begin
		ext_busy = 1'b0;
		hw_prot = 1'b0;
	end

	sfl_host_model host (.cs_n_o(cs_n), .sclk_o(sclk), .mosi_o(mosi));

	sfl_flash_wr_cmds #(.PAGE_REWRITE_TIME_NS(8000), .PAGE_PROGRAM_TIME_NS(6000),
		.SECTORS(8)) dut (.clk_i(clk), .rst_n_i(rst_n), .sclk_i(sclk), .cs_n_i(cs_n),
		.mosi_i(mosi), .ext_busy_i(ext_busy), .page_hw_prot_i(hw_prot),
		.arr_rd_data_i(rd_data), .target_page_o(page), .busy_flag_o(busy),
		.write_enable_latch_o(wr_latch), .sector_lock_bits_o(locks), .arr_req_o(arr));

	// array model: registered read, byte writes, page erase
	always @(posedge clk) begin
		rd_data <= mem.exists(arr.addr) ? mem[arr.addr] : 8'hff;
		if (arr.write) mem[arr.addr] = arr.data;
		if (arr.erase) begin
			erase_cnt++;
			for (c = 0; c < 256; c++) mem[{arr.addr[18:8], c[7:0]}] = 8'hff;
		end
	end

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[ERR] %s exp %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		if (error_cnt == 0 && samples_checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask

	// bounded wait for busy, then measure how long it stands
	task automatic run_cycle(input int exp);
		int i;
		int n;
		i = 0;
		n = 0;
		while (busy !== 1'b1 && i < 40) begin
			@(negedge clk);
			i++;
		end
		if (busy !== 1'b1) begin
			error_cnt++;
			results();
		end
		while (busy === 1'b1 && n < 2000) begin
			@(negedge clk);
			n++;
		end
		chk("busy_len", n, exp);
		if (n == 2000) begin
			results();
		end
	endtask

	// a refused frame starts nothing and keeps the latch
	task automatic quiet(input string what, input logic latch_exp);
		logic seen;
		seen = 1'b0;
		repeat (30) @(negedge clk) seen |= busy;
		chk(what, seen, 0);
		chk("latch_kept", wr_latch, latch_exp);
	endtask

	task automatic write_enable_cmd();
		host.frame({`SFL_OPC_WRITE_ENABLE}, 0);
		repeat (5) @(negedge clk);
		chk("latch_set", wr_latch, 1);
	endtask

	// rewrite of three bytes wrapping at the page end, top address bits set
	task automatic t_rewrite();
		for (int k = 0; k < 256; k++) mem[32'h70100 + k] = k[7:0];
		write_enable_cmd();
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'hff, 8'h01, 8'hfe, 8'h11, 8'h22, 8'h33}, 0);
		run_cycle(RW_CYC);
		chk("latch_clr", wr_latch, 0);
		chk("page", page, 11'h701);
		chk("erase", erase_cnt, 1);
		chk("cols", {mem[32'h701fe], mem[32'h701ff], mem[32'h70100], mem[32'h70180]},
			32'h11223380);
	endtask

	// program only clears bits; a rewrite sent meanwhile is refused
	task automatic t_program();
		mem[32'h105] = 8'h5a;
		mem[32'h106] = 8'h5a;
		write_enable_cmd();
		host.frame({`SFL_OPC_PAGE_PROGRAM, 8'h00, 8'h01, 8'h05, 8'h0f, 8'hf0}, 0);
		fork
			run_cycle(PG_CYC);
			begin
				repeat (20) @(negedge clk);
				host.frame({`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h01, 8'h05, 8'h77}, 0);
				host.frame({`SFL_OPC_LOCK_WRITE, 8'h01, 8'h00, 8'h00, 8'h01}, 0);
			end
		join
		chk("busy_lock", locks[1], 8'h00);
		quiet("after_busy", 0);
		chk("prog", {mem[32'h105], mem[32'h106]}, 16'h0a50);
		chk("erase_prog", erase_cnt, 1);
	endtask

	// refusals: no latch, cut byte, other busy, protected page, no data
	task automatic t_refuse();
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h02, 8'h00, 8'haa}, 0);
		quiet("no_wel", 0);
		write_enable_cmd();
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h02, 8'h00, 8'haa}, 3);
		quiet("mid_byte", 1);
		ext_busy = 1'b1;
		host.frame({`SFL_OPC_PAGE_PROGRAM, 8'h00, 8'h02, 8'h00, 8'haa}, 0);
		quiet("ext_busy", 1);
		ext_busy = 1'b0;
		hw_prot = 1'b1;
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h02, 8'h00, 8'haa}, 0);
		quiet("hw_prot", 1);
		hw_prot = 1'b0;
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h02, 8'h00}, 0);
		quiet("no_data", 1);
		chk("prot_mem", mem.exists(32'h200), 0);
	endtask

	task automatic lockw(input logic [7:0] q[$], input logic [7:0] exp, input logic latch_exp);
		host.frame(q, 0);
		repeat (8) @(negedge clk);
		chk("lock_bits", locks[2], exp);
		chk("latch_lock", wr_latch, latch_exp);
	endtask

	// lock writes: set, enforce, bad length, lock-down freeze
	task automatic t_lock();
		write_enable_cmd();
		lockw({`SFL_OPC_LOCK_WRITE, 8'h02, 8'h34, 8'h56, 8'h01}, 8'h01, 0);
		write_enable_cmd();
		host.frame({`SFL_OPC_PAGE_REWRITE, 8'h02, 8'h00, 8'h10, 8'h55}, 0);
		quiet("locked", 1);
		lockw({`SFL_OPC_LOCK_WRITE, 8'h02, 8'h00, 8'h00, 8'h03, 8'h00}, 8'h01, 1);
		lockw({`SFL_OPC_LOCK_WRITE, 8'h02, 8'h00, 8'h00, 8'h03}, 8'h03, 0);
		write_enable_cmd();
		lockw({`SFL_OPC_LOCK_WRITE, 8'h02, 8'h00, 8'h00, 8'h00}, 8'h03, 1);
		chk("other_sect", locks[3], 8'h00);
	endtask

	// 258 data bytes: the last two land again on columns 0 and 1
	task automatic t_overflow();
		logic [7:0] q[$];
		int         i;
		q = {`SFL_OPC_PAGE_REWRITE, 8'h00, 8'h03, 8'h00};
		for (i = 0; i < 258; i++) q.push_back(i[8:1]);
		write_enable_cmd();
		host.frame(q, 0); // one long sequence
		run_cycle(RW_CYC);
		chk("ovf", {mem[32'h300], mem[32'h301], mem[32'h302]}, 24'h808001);
	endtask

	// reset, then every scenario in turn
	initial begin
		rst_n = 1'b1;
		#1 rst_n = 1'b0; // clean falling edge so every reset branch runs
		repeat (8) @(negedge clk);
		rst_n = 1'b1;
		chk("rst", {busy, wr_latch, |locks}, 32'h0);
		t_rewrite();
		t_program();
		t_refuse();
		t_lock();
		t_overflow();
		results();
	end
endmodule
`default_nettype wire
